/* File: core/pm_smi_sci_event_route.sv */
// Power-management event routing: input routing, I/O watch and APM ports.
//
// Contract
// - Each input owns two routing bits; 00 none, 01 SMI, 10 SCI, 11 reserved.
// - Routed input fires only on status rising with its event enable set.
// - A pin not configured as input ignores its routing field.
// - In sleep S1-S5 an enabled input event wakes regardless of routing.
// - Routing fields for inputs 2,3,4,10,14,15 are reserved and never route.
// - Range one base matches I/O accesses and raises SMI when enabled.
// - Range two base matches I/O accesses and raises SMI when enabled.
// - A monitor hit only signals; the I/O cycle is never trapped or held.
// - Mask bits 3:0 exclude low address bits for range one.
// - Mask bits 7:4 do likewise for range two; bits 15:8 reserved.
// - APM ports sit fixed at B2h and B3h, decoded only when enabled.
// - A write to B2h latches the byte and raises SMI when enabled.
// - The B3h scratch port changes only by its own write or reset.
module pm_smi_sci_event_route (
  input  wire logic        clk,
  input  wire logic        rst,
  // Configuration space access.
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [31:0] cfg_wdata,
  input  wire logic [3:0]  cfg_be,
  output logic [31:0]      cfg_rdata,
  // Processor I/O cycles, one-cycle strobes.
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic [15:0] io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic [7:0]       io_rdata,
  output logic             io_claim,
  // Control bits held elsewhere.
  input  wire logic        apm_port_decode_enable,
  input  wire logic        apm_command_irq_enable,
  input  wire logic        watch_one_irq_enable,
  input  wire logic        watch_two_irq_enable,
  input  wire logic        sleeping,
  // General-purpose inputs.
  input  wire logic [15:0] input_event_status,
  input  wire logic [15:0] input_event_enable,
  input  wire logic [15:0] pin_is_input,
  // Event requests, one-cycle pulses, and the latched APM command byte.
  output logic             sys_mgmt_irq,
  output logic             acpi_ctrl_irq,
  output logic             wake_event,
  output logic [7:0]       apm_command_value
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [31:0] routing_q,    routing_d;
  logic [15:0] base_one_q,   base_one_d;
  logic [15:0] base_two_q,   base_two_d;
  logic [15:0] watch_msk_q,  watch_msk_d;
  logic [7:0]  apm_cmd_q,    apm_cmd_d;
  logic [7:0]  apm_scr_q,    apm_scr_d;
  logic [15:0] status_prev_q, status_prev_d;
  logic        smi_q,        smi_d;
  logic        sci_q,        sci_d;
  logic        wake_q,       wake_d;
  logic [7:0]  io_rdata_q,   io_rdata_d;
  logic [31:0] cfg_rdata_q,  cfg_rdata_d;
  logic        hit_one;
  logic        hit_two;
  logic        io_valid;
  logic [15:0] rise;
  logic [15:0] route_smi;
  logic [15:0] route_sci;
  logic [31:0] route_keep;
  logic        apm_cmd_hit;
  logic        apm_scr_hit;

  // Mask field positions inside the watch mask register.
  localparam int WATCH_ONE_LO = pm_event_pkg::WATCH_ONE_MSK_LO;
  localparam int WATCH_TWO_LO = pm_event_pkg::WATCH_TWO_MSK_LO;

  assign io_valid = io_wr || io_rd;

  // ==========================================================================
  // I/O monitor comparators
  // ==========================================================================
  io_range_watch u_watch_one (
    .base     (base_one_q),
    .low_mask (watch_msk_q[WATCH_ONE_LO +: 4]),
    .io_addr  (io_addr),
    .io_valid (io_valid),
    .hit      (hit_one)
  );

  io_range_watch u_watch_two (
    .base     (base_two_q),
    .low_mask (watch_msk_q[WATCH_TWO_LO +: 4]),
    .io_addr  (io_addr),
    .io_valid (io_valid),
    .hit      (hit_two)
  );

  // ==========================================================================
  // Per-input routing decode
  // ==========================================================================
  assign rise = input_event_status & ~status_prev_q;

  for (genvar n = 0; n < pm_event_pkg::NUM_INPUTS; n++) begin : g_route
    logic armed;
    // Only implemented, input-configured pins with a new enabled event route.
    assign armed = pm_event_pkg::ROUTE_IMPL[n]
                   && pin_is_input[n]
                   && rise[n] && input_event_enable[n];
    assign route_smi[n] = armed && (routing_q[2*n +: 2] ==
                          pm_event_pkg::ROUTE_SMI);
    assign route_sci[n] = armed && (routing_q[2*n +: 2] ==
                          pm_event_pkg::ROUTE_SCI);
    // Reserved bit pairs are kept at zero on every write.
    assign route_keep[2*n +: 2] = {2{pm_event_pkg::ROUTE_IMPL[n]}};
  end

  // ==========================================================================
  // APM port decode
  // ==========================================================================
  assign apm_cmd_hit = apm_port_decode_enable
                       && (io_addr == pm_event_pkg::APM_CMD_ADDR);
  assign apm_scr_hit = apm_port_decode_enable
                       && (io_addr == pm_event_pkg::APM_SCRATCH_ADDR);

  // Monitor hits never claim a cycle; only the APM ports are claimed.
  assign io_claim = io_valid && (apm_cmd_hit || apm_scr_hit);

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  // Byte-enabled configuration writes. Reserved bits are forced to zero on
  // every write, so software never reads back a field that does not exist.
  always_comb begin
    routing_d   = routing_q;
    base_one_d  = base_one_q;
    base_two_d  = base_two_q;
    watch_msk_d = watch_msk_q;
    if (cfg_wr) begin
      unique case (cfg_addr)
        pm_event_pkg::CFG_ROUTING_OFS: begin
          for (int b = 0; b < 4; b++) begin
            if (cfg_be[b]) begin
              routing_d[8*b +: 8] = cfg_wdata[8*b +: 8];
            end
          end
          // Unimplemented fields stay zero.
          routing_d = routing_d & route_keep;
        end
        pm_event_pkg::CFG_WATCH_ONE_OFS: begin
          // Base two shares this word through byte lanes 2 and 3.
          if (cfg_be[0]) begin
            base_one_d[7:0] = cfg_wdata[7:0];
          end
          if (cfg_be[1]) begin
            base_one_d[15:8] = cfg_wdata[15:8];
          end
          if (cfg_be[2]) begin
            base_two_d[7:0] = cfg_wdata[23:16];
          end
          if (cfg_be[3]) begin
            base_two_d[15:8] = cfg_wdata[31:24];
          end
        end
        pm_event_pkg::CFG_WATCH_MSK_OFS: begin
          // Only byte lane 0 carries mask bits; the upper byte is reserved.
          if (cfg_be[0]) begin
            watch_msk_d[7:0] = cfg_wdata[7:0];
          end
          watch_msk_d = watch_msk_d
                        & pm_event_pkg::WATCH_MSK_VALID;
        end
        default: begin
        end
      endcase
    end
  end

  // Configuration registers; reset clears every field.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      routing_q   <= pm_event_pkg::ROUTING_RESET;
      base_one_q  <= pm_event_pkg::WATCH_RESET;
      base_two_q  <= pm_event_pkg::WATCH_RESET;
      watch_msk_q <= pm_event_pkg::WATCH_RESET;
    end else begin
      routing_q   <= routing_d;
      base_one_q  <= base_one_d;
      base_two_q  <= base_two_d;
      watch_msk_q <= watch_msk_d;
    end
  end

  // ==========================================================================
  // APM command and scratch ports
  // ==========================================================================
  // Each port takes the byte of a decoded I/O write and nothing else, so
  // neither a monitor hit nor an input event can disturb it.
  always_comb begin
    apm_cmd_d = apm_cmd_q;
    apm_scr_d = apm_scr_q;
    if (io_wr && apm_cmd_hit) begin
      apm_cmd_d = io_wdata;
    end
    if (io_wr && apm_scr_hit) begin
      apm_scr_d = io_wdata;
    end
  end

  // Port registers; reset returns them to zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      apm_cmd_q <= pm_event_pkg::APM_RESET;
      apm_scr_q <= pm_event_pkg::APM_RESET;
    end else begin
      apm_cmd_q <= apm_cmd_d;
      apm_scr_q <= apm_scr_d;
    end
  end

  // ==========================================================================
  // Read data
  // ==========================================================================
  // Read data is zero unless a read strobe selects a register, so a stale
  // value can never be taken for an answer. It stands for one cycle.
  always_comb begin
    cfg_rdata_d = 32'h0000_0000;
    io_rdata_d  = 8'h00;
    if (cfg_rd) begin
      unique case (cfg_addr)
        pm_event_pkg::CFG_ROUTING_OFS: begin
          cfg_rdata_d = routing_q;
        end
        pm_event_pkg::CFG_WATCH_ONE_OFS: begin
          cfg_rdata_d = {base_two_q, base_one_q};
        end
        pm_event_pkg::CFG_WATCH_MSK_OFS: begin
          cfg_rdata_d = {16'h0000, watch_msk_q};
        end
        default: begin
          cfg_rdata_d = 32'h0000_0000;
        end
      endcase
    end
    if (io_rd && apm_cmd_hit) begin
      io_rdata_d = apm_cmd_q;
    end else if (io_rd && apm_scr_hit) begin
      io_rdata_d = apm_scr_q;
    end
  end

  // Read data registers.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_rdata_q <= 32'h0000_0000;
      io_rdata_q  <= 8'h00;
    end else begin
      cfg_rdata_q <= cfg_rdata_d;
      io_rdata_q  <= io_rdata_d;
    end
  end

  // ==========================================================================
  // Event requests
  // ==========================================================================
  // Requests are single-cycle pulses. A strobe lasts one cycle, so each
  // matching access yields exactly one request, even when both ranges hit.
  always_comb begin
    status_prev_d = input_event_status;
    smi_d = (|route_smi)
            || (hit_one && watch_one_irq_enable)
            || (hit_two && watch_two_irq_enable)
            || (io_wr && apm_cmd_hit
                && apm_command_irq_enable);
    sci_d = |route_sci;
    // Sleep wake ignores the routing code and the unimplemented fields.
    wake_d = sleeping
             && |(rise & input_event_enable & pin_is_input);
  end

  // Event pulse registers and the previous status level.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_prev_q <= 16'h0000;
      smi_q         <= 1'b0;
      sci_q         <= 1'b0;
      wake_q        <= 1'b0;
    end else begin
      status_prev_q <= status_prev_d;
      smi_q         <= smi_d;
      sci_q         <= sci_d;
      wake_q        <= wake_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Outputs other than io_claim come straight from flip-flops.
  assign sys_mgmt_irq      = smi_q;
  assign acpi_ctrl_irq     = sci_q;
  assign wake_event        = wake_q;
  assign apm_command_value = apm_cmd_q;
  assign io_rdata          = io_rdata_q;
  assign cfg_rdata         = cfg_rdata_q;

endmodule : pm_smi_sci_event_route

/* File: core/pm_event_pkg.sv */
// Package with offsets, field layouts and reset values for the event router.
package pm_event_pkg;

  // ==========================================================================
  // Configuration space offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] CFG_ROUTING_OFS   = 8'hB8;
  localparam logic [7:0] CFG_WATCH_ONE_OFS = 8'hC4;
  localparam logic [7:0] CFG_WATCH_TWO_OFS = 8'hC6;
  localparam logic [7:0] CFG_WATCH_MSK_OFS = 8'hCC;

  // ==========================================================================
  // Fixed I/O addresses of the APM ports
  // ==========================================================================
  localparam logic [15:0] APM_CMD_ADDR     = 16'h00B2;
  localparam logic [15:0] APM_SCRATCH_ADDR = 16'h00B3;

  // ==========================================================================
  // Field layouts and reset values
  // ==========================================================================
  localparam int          NUM_INPUTS       = 16;
  localparam int          MASK_BITS        = 4;
  localparam int          WATCH_ONE_MSK_LO = 0;
  localparam int          WATCH_TWO_MSK_LO = 4;
  // Set bits mark inputs whose routing field is implemented.
  localparam logic [15:0] ROUTE_IMPL       = 16'h3BE3;
  localparam logic [31:0] ROUTING_RESET    = 32'h0000_0000;
  localparam logic [15:0] WATCH_RESET      = 16'h0000;
  localparam logic [15:0] WATCH_MSK_VALID  = 16'h00FF;
  localparam logic [7:0]  APM_RESET        = 8'h00;

  // Two-bit routing codes.
  typedef enum logic [1:0] {
    ROUTE_NONE = 2'h0,
    ROUTE_SMI  = 2'h1,
    ROUTE_SCI  = 2'h2,
    ROUTE_RSVD = 2'h3
  } route_code_t;

endpackage : pm_event_pkg

/* File: core/io_range_watch.sv */
// One I/O monitor range comparator with a four-bit low mask.
module io_range_watch (
  input  wire logic [15:0] base,
  input  wire logic [3:0]  low_mask,
  input  wire logic [15:0] io_addr,
  input  wire logic        io_valid,
  output logic             hit
);

  logic [15:0] care;

  // Masked low bits are excluded; all other bits must match.
  always_comb begin
    care = {12'hFFF, ~low_mask};
    hit  = io_valid && (((io_addr ^ base) & care) == 16'h0000);
  end

endmodule : io_range_watch

/* File: test/pm_event_route_properties.sv */
// Port checks for the event router.
module pm_event_route_properties (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        io_wr,
  input wire logic        io_rd,
  input wire logic [15:0] io_addr,
  input wire logic [7:0]  io_wdata,
  input wire logic        io_claim,
  input wire logic        apm_port_decode_enable,
  input wire logic        apm_command_irq_enable,
  input wire logic        sleeping,
  input wire logic [15:0] input_event_status,
  input wire logic [15:0] input_event_enable,
  input wire logic [15:0] pin_is_input,
  input wire logic        sys_mgmt_irq,
  input wire logic        acpi_ctrl_irq,
  input wire logic        wake_event,
  input wire logic [7:0]  apm_command_value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] stat_q;
  logic [15:0] rise;
  logic        apm_hit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Previous status level, so a rise of each input can be seen.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) stat_q <= 16'h0000;
    else stat_q <= input_event_status;
  end
  // Rising, enabled inputs on input pins, and APM port address decode.
  assign rise = input_event_status & ~stat_q & input_event_enable
                & pin_is_input;
  assign apm_hit = io_addr == pm_event_pkg::APM_CMD_ADDR
                   || io_addr == pm_event_pkg::APM_SCRATCH_ADDR;
  sequence cmd_wr_s;
    io_wr && io_addr == pm_event_pkg::APM_CMD_ADDR && apm_port_decode_enable;
  endsequence
  // ==========================================================================
  // Assertions
  // ==========================================================================
  cmd_latch_a: assert property (cmd_wr_s |=>
    apm_command_value == $past(io_wdata)) else $error("command byte lost");
  cmd_irq_a: assert property (cmd_wr_s ##0 apm_command_irq_enable
    |=> sys_mgmt_irq) else $error("command write without request");
  apm_claim_a: assert property ((io_wr || io_rd) && apm_hit
    && apm_port_decode_enable |-> io_claim) else $error("port not claimed");
  no_decode_a: assert property (!apm_port_decode_enable
    |-> !io_claim) else $error("claim while decode off");
  watch_no_claim_a: assert property ((io_wr || io_rd) && !apm_hit
    |-> !io_claim) else $error("monitored cycle claimed");
  smi_cause_a: assert property (sys_mgmt_irq |->
    $past(io_wr || io_rd || (|rise))) else $error("request without cause");
  sci_cause_a: assert property (acpi_ctrl_irq |->
    $past(|(rise & pm_event_pkg::ROUTE_IMPL))) else $error("stray request");
  wake_rise_a: assert property (sleeping && (|rise)
    |=> wake_event) else $error("wake missing");
endmodule : pm_event_route_properties

bind pm_smi_sci_event_route pm_event_route_properties props (
  .clk(clk), .rst(rst), .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr),
  .io_wdata(io_wdata), .io_claim(io_claim), .sleeping(sleeping),
  .apm_port_decode_enable(apm_port_decode_enable),
  .apm_command_irq_enable(apm_command_irq_enable),
  .input_event_status(input_event_status),
  .input_event_enable(input_event_enable), .pin_is_input(pin_is_input),
  .sys_mgmt_irq(sys_mgmt_irq), .acpi_ctrl_irq(acpi_ctrl_irq),
  .wake_event(wake_event), .apm_command_value(apm_command_value));

/* File: test/host_cycles.sv */
// Host model issuing configuration and I/O cycles.
module host_cycles (
  input  wire logic [31:0] cfg_rdata,
  input  wire logic [7:0]  io_rdata,
  input  wire logic        io_claim,
  input  wire logic        clk,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic [7:0]       cfg_addr,
  output logic [31:0]      cfg_wdata,
  output logic [3:0]       cfg_be,
  output logic             io_wr,
  output logic             io_rd,
  output logic [15:0]      io_addr,
  output logic [7:0]       io_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle at time zero, all byte lanes enabled.
  initial begin
    {cfg_wr, cfg_rd, io_wr, io_rd, cfg_addr, cfg_wdata} = '0;
    {io_addr, io_wdata} = '0;
    cfg_be = 4'hF;
  end
  // One configuration cycle; read data stands the cycle after.
  task automatic cfg(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    #1;
    {cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {w, !w, a, d};
    @(posedge clk);
    #1;
    {cfg_wr, cfg_rd} = 2'b00;
    q = cfg_rdata;
  endtask : cfg
  // One I/O cycle; claim is seen in the strobe cycle, data after it.
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d,
                    output logic [7:0] q, output logic c);
    @(posedge clk);
    #1;
    {io_wr, io_rd, io_addr, io_wdata} = {w, !w, a, d};
    #1;
    c = io_claim;
    @(posedge clk);
    #1;
    {io_wr, io_rd} = 2'b00;
    q = io_rdata;
  endtask : io
endmodule : host_cycles

/* File: test/pm_smi_sci_event_route_test.sv */
// Testbench for the event router.
module pm_smi_sci_event_route_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, wr, rd, iwr, ird, ce, dec, cie, w1, w2, slp, smi, sci, wk;
  logic [7:0] ca, iwd, ird_d, cmdv;
  logic [31:0] wd, rdd, q;
  logic [3:0] be;
  logic [15:0] ia, st, en, pin;
  int n_mismatch, cmp_count, n_smi, n_sci, n_wake;
  host_cycles h (.clk(clk), .cfg_rdata(rdd), .io_rdata(ird_d),
    .io_claim(ce), .cfg_wr(wr), .cfg_rd(rd), .cfg_addr(ca), .cfg_wdata(wd),
    .cfg_be(be), .io_wr(iwr), .io_rd(ird), .io_addr(ia), .io_wdata(iwd));
  pm_smi_sci_event_route DUT (.clk(clk), .rst(rst), .cfg_wr(wr),
    .cfg_rd(rd), .cfg_addr(ca), .cfg_wdata(wd), .cfg_be(be),
    .cfg_rdata(rdd), .io_wr(iwr), .io_rd(ird), .io_addr(ia),
    .io_wdata(iwd), .io_rdata(ird_d), .io_claim(ce),
    .apm_port_decode_enable(dec), .apm_command_irq_enable(cie),
    .watch_one_irq_enable(w1), .watch_two_irq_enable(w2), .sleeping(slp),
    .input_event_status(st), .input_event_enable(en), .pin_is_input(pin),
    .sys_mgmt_irq(smi), .acpi_ctrl_irq(sci), .wake_event(wk),
    .apm_command_value(cmdv));
  // Clock and pulse counters.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_smi += (smi === 1'b1);
    n_sci += (sci === 1'b1);
    n_wake += (wk === 1'b1);
  end
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : check
  task automatic test_done;
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  // One input event: rise input n and count the requests that follow.
  task automatic ev(int n, logic e, logic p, logic s, int xs, xc, xw);
    int s0, c0, w0;
    {s0, c0, w0} = {n_smi, n_sci, n_wake};
    {en, pin, slp} = {16'(e) << n, ~(16'(!p) << n), s};
    @(posedge clk);
    #1;
    st[n] = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    st[n] = 1'b0;
    check(n_smi - s0, xs);
    check(n_sci - c0, xc);
    check(n_wake - w0, xw);
  endtask : ev
  // One I/O cycle with expected request count, read data and claim.
  task automatic iot(logic w, logic [15:0] a, logic [7:0] d, int xs,
                     logic [7:0] xq, logic xc);
    int s0;
    logic c;
    s0 = n_smi;
    h.io(w, a, d, q[7:0], c);
    repeat (2) @(posedge clk);
    #1;
    check(n_smi - s0, xs);
    check(q[7:0], xq);
    check(c, xc);
  endtask : iot
  // Main sequence.
  initial begin
    {rst, dec, cie, w1, w2, slp, st, en, pin} = {1'b1, 53'h0};
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    for (int i = 0; i < 3; i++) begin
      h.cfg(0, i == 0 ? 8'hB8 : i == 1 ? 8'hC4 : 8'hCC, 0, q);
      check(q, 32'h0000_0000);
    end
    h.cfg(1, 8'hB8, 32'hFFFF_FFFF, q);
    h.cfg(0, 8'hB8, 0, q);
    check(q, 32'h0FCF_FC0F);
    h.cfg(1, 8'hCC, 32'hFFFF_FFFF, q);
    h.cfg(0, 8'hCC, 0, q);
    check(q, 32'h0000_00FF);
    h.cfg(1, 8'hB8, 32'h0000_0C19, q);
    ev(0, 1, 1, 0, 1, 0, 0);
    ev(1, 1, 1, 0, 0, 1, 0);
    ev(5, 1, 1, 0, 0, 0, 0);
    ev(6, 1, 1, 0, 0, 0, 0);
    ev(0, 0, 1, 0, 0, 0, 0);
    ev(1, 1, 0, 0, 0, 0, 0);
    ev(2, 1, 1, 0, 0, 0, 0);
    ev(6, 1, 1, 1, 0, 0, 1);
    ev(2, 1, 1, 1, 0, 0, 1);
    h.cfg(1, 8'hC4, 32'h0400_1230, q);
    h.cfg(1, 8'hCC, 32'h0000_0003, q);
    {w1, w2} = 2'b11;
    iot(0, 16'h1233, 0, 1, 0, 0);
    iot(1, 16'h1230, 0, 1, 0, 0);
    iot(0, 16'h1234, 0, 0, 0, 0);
    iot(0, 16'h0400, 0, 1, 0, 0);
    iot(0, 16'h0401, 0, 0, 0, 0);
    iot(0, 16'h5231, 0, 0, 0, 0);
    h.cfg(1, 8'hCC, 32'h0000_0013, q);
    iot(0, 16'h0401, 0, 1, 0, 0);
    w1 = 1'b0;
    iot(0, 16'h1230, 0, 0, 0, 0);
    {dec, cie} = 2'b11;
    iot(1, 16'h00B2, 8'h5A, 1, 0, 1);
    check(cmdv, 8'h5A);
    iot(0, 16'h00B2, 0, 0, 8'h5A, 1);
    iot(1, 16'h00B3, 8'hC3, 0, 0, 1);
    iot(0, 16'h00B3, 0, 0, 8'hC3, 1);
    cie = 1'b0;
    iot(1, 16'h00B2, 8'h66, 0, 0, 1);
    dec = 1'b0;
    iot(1, 16'h00B2, 8'h77, 0, 0, 0);
    check(cmdv, 8'h66);
    test_done();
  end
endmodule : pm_smi_sci_event_route_test
